// ---- rtl/pfc_map.vh ----
// command codes, unlock addresses and bus timing for the flash host sequencer
`ifndef PFC_MAP_VH
`define PFC_MAP_VH

// unlock and lock status addresses, unlock and command data
`define PFC_ADDR_UNLOCK1   19'h05555
`define PFC_ADDR_UNLOCK2   19'h02AAA
`define PFC_ADDR_LOCKSTAT  19'h00002
`define PFC_DATA_UNLOCK1   8'hAA
`define PFC_DATA_UNLOCK2   8'h55
`define PFC_DATA_ERASE_PRE 8'h80
`define PFC_DATA_ERASE     8'h10
`define PFC_DATA_PROGRAM   8'hA0
`define PFC_DATA_LOCKOUT   8'h40
`define PFC_DATA_ID_ENTRY  8'h90
`define PFC_DATA_ID_EXIT   8'hF0

// operation codes on the user port
`define PFC_OP_READ        3'h0
`define PFC_OP_PROGRAM     3'h1
`define PFC_OP_ERASE       3'h2
`define PFC_OP_LOCKOUT     3'h3
`define PFC_OP_ID_ENTRY    3'h4
`define PFC_OP_ID_EXIT     3'h5
`define PFC_OP_ID_EXIT1    3'h6

// status bit positions
`define PFC_BIT_POLL       7
`define PFC_BIT_TOGGLE     6
`define PFC_BIT_LOCK       0

// strobe timing at 50 ns per cycle
`define PFC_CLK_NS         50
`define PFC_STROBE_NS      100
`define PFC_STROBE_CYC     ((`PFC_STROBE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_READ_NS        150
`define PFC_READ_CYC       ((`PFC_READ_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_CNT_W          3

`endif

// ---- rtl/pfc_bus_cycle.v ----
// one flash bus cycle: a write strobe pulse or an output-enabled read
`timescale 1ns/10ps
`default_nettype none
module pfc_bus_cycle
(
  // clock and reset
  input  wire        clock,
  input  wire        rst,
  // request
  input  wire        start,
  input  wire        is_write,
  input  wire [18:0] addr_in,
  input  wire [7:0]  wdata_in,
  output reg         done,
  output reg  [7:0]  rdata,
  // flash pins
  output reg  [18:0] addr_lines,
  output reg  [7:0]  data_lines_out,
  output reg         data_lines_oe,
  input  wire [7:0]  data_lines_in,
  output reg         chip_sel_n,
  output reg         out_en_n,
  output reg         write_en_n
);
`include "pfc_map.vh"

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_SETUP = 2'h1;
  localparam [1:0] ST_PULSE = 2'h2;
  localparam [1:0] ST_HOLD  = 2'h3;
  // counts worked out as integers, then cut to the counter width on purpose
  localparam integer          STROBE_INT = `PFC_STROBE_CYC;
  localparam integer          READ_INT   = `PFC_READ_CYC;
  localparam [`PFC_CNT_W-1:0] STROBE_LEN = STROBE_INT[`PFC_CNT_W-1:0];
  localparam [`PFC_CNT_W-1:0] READ_LEN   = READ_INT[`PFC_CNT_W-1:0];

  reg [1:0]            state_reg;
  reg [`PFC_CNT_W-1:0] cnt_reg;
  reg                  wr_reg;

  // address set up one cycle before strobes so the falling edge sees it settled
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg      <= ST_IDLE;
      cnt_reg        <= 3'h0;
      wr_reg         <= 1'b0;
      done           <= 1'b0;
      rdata          <= 8'h00;
      addr_lines     <= 19'h00000;
      data_lines_out <= 8'h00;
      data_lines_oe  <= 1'b0;
      chip_sel_n     <= 1'b1;
      out_en_n       <= 1'b1;
      write_en_n     <= 1'b1;
    end
    else
    begin
      done <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (start)
          begin
            addr_lines     <= addr_in;
            data_lines_out <= wdata_in;
            wr_reg         <= is_write;
            data_lines_oe  <= is_write;
            chip_sel_n     <= 1'b0;
            state_reg      <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          // oe stays high during writes, we high during reads (program inhibit)
          write_en_n <= ~wr_reg;
          out_en_n   <= wr_reg;
          cnt_reg    <= wr_reg ? STROBE_LEN : READ_LEN;
          state_reg  <= ST_PULSE;
        end
        ST_PULSE:
        begin
          if (cnt_reg == 3'h1)
          begin
            // data held past the rising edge where the device latches it
            write_en_n <= 1'b1;
            out_en_n   <= 1'b1;
            if (!wr_reg)
              rdata <= data_lines_in;
            state_reg <= ST_HOLD;
          end
          else
            cnt_reg <= cnt_reg - 3'h1;
        end
        ST_HOLD:
        begin
          chip_sel_n    <= 1'b1;
          data_lines_oe <= 1'b0;
          done          <= 1'b1;
          state_reg     <= ST_IDLE;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- rtl/pfc_host.v ----
// host sequencer that drives a byte-wide parallel flash through command sequences
`timescale 1ns/10ps
`default_nettype none
module pfc_host
(
  // clock and reset
  input  wire        clock,
  input  wire        rst,
  // user request port
  input  wire        req_valid,
  output wire        req_ready,
  input  wire [2:0]  req_op,
  input  wire [18:0] req_addr,
  input  wire [7:0]  req_data,
  // user answer port
  output reg         resp_valid,
  output reg  [7:0]  resp_data,
  output reg         resp_timeout,
  // flash pins
  output wire [18:0] addr_lines,
  output wire [7:0]  data_lines_out,
  output wire        data_lines_oe,
  input  wire [7:0]  data_lines_in,
  output wire        chip_sel_n,
  output wire        out_en_n,
  output wire        write_en_n
);
`include "pfc_map.vh"

  // poll limit in reads; default covers the longest erase time at one read per few cycles
  parameter [31:0] POLL_LIMIT = 32'h02000000;

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ISSUE = 3'h1;
  localparam [2:0] ST_WAIT  = 3'h2;
  localparam [2:0] ST_POLL  = 3'h3;
  localparam [2:0] ST_PWAIT = 3'h4;
  localparam [2:0] ST_RESP  = 3'h5;

  reg [2:0]  state_reg;
  reg [2:0]  op_reg;
  reg [18:0] addr_reg;
  reg [7:0]  data_reg;
  reg [2:0]  step_reg;
  reg [2:0]  nsteps;
  reg [7:0]  last_rd_reg;
  reg        have_last_reg;
  reg [31:0] poll_cnt_reg;
  reg        cyc_start;
  reg        cyc_write;
  reg [18:0] cyc_addr;
  reg [7:0]  cyc_data;
  wire       cyc_done;
  wire [7:0] cyc_rdata;

  assign req_ready = (state_reg == ST_IDLE);

  // number of bus cycles in each command
  always @*
  begin
    case (op_reg)
      `PFC_OP_PROGRAM:  nsteps = 3'h4;
      `PFC_OP_ERASE:    nsteps = 3'h6;
      `PFC_OP_LOCKOUT:  nsteps = 3'h6;
      `PFC_OP_ID_ENTRY: nsteps = 3'h3;
      `PFC_OP_ID_EXIT:  nsteps = 3'h3;
      default:          nsteps = 3'h1;
    endcase
  end

  // address and data of the current step; sequences emitted whole so none is broken
  always @*
  begin
    cyc_write = (op_reg != `PFC_OP_READ);
    cyc_addr  = `PFC_ADDR_UNLOCK1;
    cyc_data  = `PFC_DATA_UNLOCK1;
    case (step_reg)
      3'h0:
      begin
        cyc_addr = `PFC_ADDR_UNLOCK1;
        cyc_data = `PFC_DATA_UNLOCK1;
      end
      3'h1, 3'h4:
      begin
        cyc_addr = `PFC_ADDR_UNLOCK2;
        cyc_data = `PFC_DATA_UNLOCK2;
      end
      3'h2:
      begin
        case (op_reg)
          `PFC_OP_PROGRAM:  cyc_data = `PFC_DATA_PROGRAM;
          `PFC_OP_ID_ENTRY: cyc_data = `PFC_DATA_ID_ENTRY;
          `PFC_OP_ID_EXIT:  cyc_data = `PFC_DATA_ID_EXIT;
          default:          cyc_data = `PFC_DATA_ERASE_PRE;
        endcase
      end
      3'h3:
      begin
        if (op_reg == `PFC_OP_PROGRAM)
        begin
          cyc_addr = addr_reg;
          cyc_data = data_reg;
        end
      end
      3'h5:
        cyc_data = (op_reg == `PFC_OP_LOCKOUT) ? `PFC_DATA_LOCKOUT : `PFC_DATA_ERASE;
      default:
        cyc_data = `PFC_DATA_UNLOCK1;
    endcase
    // single-cycle forms: plain read, or id exit to any address
    if (op_reg == `PFC_OP_READ)
      cyc_addr = addr_reg;
    else if (op_reg == `PFC_OP_ID_EXIT1)
    begin
      cyc_addr = addr_reg;
      cyc_data = `PFC_DATA_ID_EXIT;
    end
  end

  // command sequencer with completion polling
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg     <= ST_IDLE;
      op_reg        <= `PFC_OP_READ;
      addr_reg      <= 19'h00000;
      data_reg      <= 8'h00;
      step_reg      <= 3'h0;
      last_rd_reg   <= 8'h00;
      have_last_reg <= 1'b0;
      poll_cnt_reg  <= 32'h00000000;
      cyc_start     <= 1'b0;
      resp_valid    <= 1'b0;
      resp_data     <= 8'h00;
      resp_timeout  <= 1'b0;
    end
    else
    begin
      cyc_start  <= 1'b0;
      resp_valid <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (req_valid)
          begin
            op_reg    <= req_op;
            addr_reg  <= req_addr;
            data_reg  <= req_data;
            step_reg  <= 3'h0;
            state_reg <= ST_ISSUE;
          end
        end
        ST_ISSUE:
        begin
          cyc_start <= 1'b1;
          state_reg <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (cyc_done)
          begin
            if (step_reg != nsteps - 3'h1)
            begin
              step_reg  <= step_reg + 3'h1;
              state_reg <= ST_ISSUE;
            end
            else if (op_reg == `PFC_OP_PROGRAM || op_reg == `PFC_OP_ERASE || op_reg == `PFC_OP_LOCKOUT)
            begin
              // completion found by toggle bit, from whatever point polling starts
              have_last_reg <= 1'b0;
              poll_cnt_reg  <= 32'h00000000;
              state_reg     <= ST_POLL;
            end
            else
            begin
              resp_data    <= cyc_rdata;
              resp_timeout <= 1'b0;
              state_reg    <= ST_RESP;
            end
          end
        end
        ST_POLL:
        begin
          op_reg    <= `PFC_OP_READ;
          cyc_start <= 1'b1;
          state_reg <= ST_PWAIT;
        end
        ST_PWAIT:
        begin
          if (cyc_done)
          begin
            last_rd_reg   <= cyc_rdata;
            have_last_reg <= 1'b1;
            poll_cnt_reg  <= poll_cnt_reg + 32'h00000001;
            // two equal toggle bits in a row mean the device finished
            if (have_last_reg && last_rd_reg[`PFC_BIT_TOGGLE] == cyc_rdata[`PFC_BIT_TOGGLE])
            begin
              resp_data    <= cyc_rdata;
              resp_timeout <= 1'b0;
              state_reg    <= ST_RESP;
            end
            else if (poll_cnt_reg == POLL_LIMIT - 32'h00000001) // give up after exactly the limit of reads
            begin
              resp_data    <= cyc_rdata;
              resp_timeout <= 1'b1;
              state_reg    <= ST_RESP;
            end
            else
              state_reg <= ST_POLL;
          end
        end
        ST_RESP:
        begin
          resp_valid <= 1'b1;
          state_reg  <= ST_IDLE;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // pin-level bus cycle engine
  pfc_bus_cycle pfc_bus_cycle_inst
  (
    .clock          (clock),
    .rst            (rst),
    .start          (cyc_start),
    .is_write       (cyc_write),
    .addr_in        (cyc_addr),
    .wdata_in       (cyc_data),
    .done           (cyc_done),
    .rdata          (cyc_rdata),
    .addr_lines     (addr_lines),
    .data_lines_out (data_lines_out),
    .data_lines_oe  (data_lines_oe),
    .data_lines_in  (data_lines_in),
    .chip_sel_n     (chip_sel_n),
    .out_en_n       (out_en_n),
    .write_en_n     (write_en_n)
  );
endmodule
`default_nettype wire

// ---- bench/pfc_host_assertions.sv ----
// concurrent checks on the flash host pins and user port
`timescale 1ns/10ps
`default_nettype none
module pfc_host_assertions
(
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // watched ports
  input wire logic        req_ready,
  input wire logic        resp_valid,
  input wire logic [18:0] addr_lines,
  input wire logic [7:0]  data_lines_out,
  input wire logic        data_lines_oe,
  input wire logic        chip_sel_n,
  input wire logic        out_en_n,
  input wire logic        write_en_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // two low cycles keep the write pulse well clear of the noise filter
  sequence we_pulse;
    !write_en_n [*2] ##1 write_en_n;
  endsequence
  // read access of three cycles covers the slowest access time
  sequence oe_pulse;
    !out_en_n [*3] ##1 out_en_n;
  endsequence
  AST_WE_WIDTH: assert property ($fell(write_en_n) |-> we_pulse) else $error("write pulse width");
  AST_OE_WIDTH: assert property ($fell(out_en_n) |-> oe_pulse) else $error("read pulse width");
  AST_NO_OE_WE: assert property (!(!out_en_n && !write_en_n)) else $error("write with output enabled");
  AST_OE_CS: assert property (!out_en_n |-> !chip_sel_n) else $error("read without select");
  AST_NO_FIGHT: assert property (data_lines_oe |-> out_en_n) else $error("bus contention");
  AST_WE_CS: assert property ($fell(write_en_n) |-> $past(!chip_sel_n)) else $error("select late");
  AST_HOLD: assert property (!chip_sel_n && $past(!chip_sel_n) |-> $stable(addr_lines) && $stable(data_lines_out))
    else $error("address or data moved");
  AST_GAP: assert property ($rose(chip_sel_n) |=> chip_sel_n) else $error("no idle gap");
  AST_READY: assert property (resp_valid |-> req_ready ##1 !resp_valid) else $error("ready not back");
  AST_IDLE: assert property (req_ready |-> chip_sel_n && write_en_n && out_en_n) else $error("strobe in idle");
endmodule
`default_nettype wire

// ---- bench/pfc_flash_model.sv ----
// behavioural byte-wide flash seen from the host pins
`timescale 1ns/10ps
`default_nettype none
`include "pfc_map.vh"
module pfc_flash_model
#(
  parameter       PROG_NS  = 2000,
  parameter       ERASE_NS = 3000,
  parameter       TOP_BOOT = 0,
  parameter [7:0] MFR_ID   = 8'hA5, // arbitrary value
  parameter [7:0] DEV_ID   = 8'h3C  // arbitrary value
)
(
  // host pins
  input  wire logic [18:0] addr_lines,
  input  wire logic [7:0]  host_data,
  input  wire logic        host_oe,
  input  wire logic        chip_sel_n,
  input  wire logic        out_en_n,
  input  wire logic        write_en_n,
  // resolved bus
  output var  logic [7:0]  bus
);
  logic [7:0]  mem [0:524287];
  logic [18:0] la;
  logic [7:0]  ld = 8'hFF;
  logic        busy = 0, tog = 0, idm = 0, lock = 0;
  int          step = 0;
  realtime     tf;
  // the array starts erased
  initial foreach (mem[i]) mem[i] = 8'hFF;
  function automatic logic boot(input logic [18:0] a);
    return TOP_BOOT ? a >= 19'h7C000 : a <= 19'h03FFF;
  endfunction
  function automatic logic [7:0] rd(input logic [18:0] a);
    if (busy) return {~ld[7], tog, 6'h00};
    if (idm && a < 19'h00003) return a == 0 ? MFR_ID : a == 1 ? DEV_ID : {7'h00, lock};
    return mem[a];
  endfunction
  // undriven bus shows the inverse, never a stale match
  // status state read inside rd is listed by hand so status changes reach the bus; the array mem is not listed
  always @(addr_lines, host_data, host_oe, chip_sel_n, out_en_n, write_en_n, busy, tog, idm, lock, ld)
    bus = host_oe ? host_data : ~chip_sel_n && ~out_en_n && write_en_n ? rd(addr_lines)
                    : ~rd(addr_lines);
  always @(posedge out_en_n) if (busy) tog = ~tog;
  always @(negedge write_en_n) if (!chip_sel_n) begin la = addr_lines; tf = $realtime; end
  always @(posedge write_en_n)
    if (!chip_sel_n && out_en_n && $realtime - tf >= 15 && !busy) cmd(la, host_data);
  task automatic run(input int t);
    fork
      begin busy = 1; #(t); busy = 0; end
    join_none
  endtask
  task automatic cmd(input logic [18:0] a, input logic [7:0] d);
    logic u1, u2;
    u1 = a == `PFC_ADDR_UNLOCK1;
    u2 = a == `PFC_ADDR_UNLOCK2;
    if (step == 0 && d == `PFC_DATA_ID_EXIT) idm = 0;
    if (step == 6)
    begin
      step = 0;
      if (!(lock && boot(a))) begin ld = d; mem[a] = mem[a] & d; run(PROG_NS); end
    end
    else if ((step == 0 || step == 3) && u1 && d == `PFC_DATA_UNLOCK1) step++;
    else if ((step == 1 || step == 4) && u2 && d == `PFC_DATA_UNLOCK2) step++;
    else if (step == 2 && u1 && d == `PFC_DATA_PROGRAM) step = 6;
    else if (step == 2 && u1 && d == `PFC_DATA_ERASE_PRE) step = 3;
    else if (step == 2 && u1 && (d == `PFC_DATA_ID_ENTRY || d == `PFC_DATA_ID_EXIT))
      begin idm = d == `PFC_DATA_ID_ENTRY; step = 0; end
    else if (step == 5 && u1 && d == `PFC_DATA_ERASE)
    begin
      step = 0;
      ld = 8'hFF;
      foreach (mem[k]) if (!(lock && boot(19'(k)))) mem[k] = 8'hFF;
      run(ERASE_NS);
    end
    else if (step == 5 && u1 && d == `PFC_DATA_LOCKOUT) begin step = 0; lock = 1; end
    else step = 0;
  endtask
endmodule
`default_nettype wire

// ---- bench/pfc_host_tb.sv ----
// self-checking bench for the flash host sequencer
`timescale 1ns/10ps
`default_nettype none
`include "pfc_map.vh"
module pfc_host_tb;
  logic        clock = 0, rst = 1, req_valid = 0;
  logic [2:0]  req_op = 0;
  logic [18:0] req_addr = 0;
  logic [7:0]  req_data = 0, data_lines_in, rdat;
  logic        rto;
  wire         req_ready, resp_valid, resp_timeout, data_lines_oe, chip_sel_n, out_en_n, write_en_n;
  wire  [7:0]  resp_data, data_lines_out;
  wire  [18:0] addr_lines;
  int          mismatches = 0, n_tests = 0;
  always #25 clock = ~clock;
  pfc_host #(.POLL_LIMIT(32'h40)) pfc_host_inst (.clock(clock), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_data(req_data), .resp_valid(resp_valid),
    .resp_data(resp_data), .resp_timeout(resp_timeout), .addr_lines(addr_lines), .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe), .data_lines_in(data_lines_in), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
    .write_en_n(write_en_n));
  pfc_flash_model pfc_flash_model_inst (.addr_lines(addr_lines), .host_data(data_lines_out),
    .host_oe(data_lines_oe), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
    .bus(data_lines_in));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin mismatches++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end
  endtask
  // one request, held until taken, then a bounded wait for the answer
  task automatic op(input logic [2:0] o, input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    req_valid <= 1; req_op <= o; req_addr <= a; req_data <= d;
    do @(posedge clock); while (req_ready !== 1'b1);
    req_valid <= 0;
    while (resp_valid !== 1'b1 && n < 4000) begin @(posedge clock); n++; end
    if (n >= 4000) begin mismatches++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 0, 1); end
    rdat = resp_data;
    rto = resp_timeout;
  endtask
  task automatic t_read;
    op(`PFC_OP_READ, 19'h12345, 8'h00);
    chk(rdat, 8'hFF);
    chk({4'h0, data_lines_oe, chip_sel_n, out_en_n, write_en_n}, 8'h07);
  endtask
  task automatic t_program;
    op(`PFC_OP_PROGRAM, 19'h04000, 8'h5A);
    chk(rdat, 8'h5A);
    chk({7'h00, rto}, 8'h00);
    op(`PFC_OP_PROGRAM, 19'h04000, 8'hF0);
    op(`PFC_OP_READ, 19'h04000, 8'h00);
    chk(rdat, 8'h50);
  endtask
  task automatic t_ident;
    op(`PFC_OP_ID_ENTRY, 19'h00000, 8'h00);
    op(`PFC_OP_READ, 19'h00000, 8'h00);
    chk(rdat, 8'hA5);
    op(`PFC_OP_READ, 19'h00002, 8'h00);
    chk(rdat, 8'h00);
    op(`PFC_OP_ID_EXIT1, 19'h00123, 8'h00);
    op(`PFC_OP_READ, 19'h00002, 8'h00);
    chk(rdat, 8'hFF);
  endtask
  task automatic t_lock;
    op(`PFC_OP_PROGRAM, 19'h00010, 8'h3C);
    op(`PFC_OP_LOCKOUT, 19'h00000, 8'h00);
    op(`PFC_OP_ID_ENTRY, 19'h00000, 8'h00);
    op(`PFC_OP_READ, 19'h00002, 8'h00);
    chk(rdat, 8'h01);
    op(`PFC_OP_ID_EXIT, 19'h00000, 8'h00);
    op(`PFC_OP_PROGRAM, 19'h00010, 8'h00);
    op(`PFC_OP_READ, 19'h00010, 8'h00);
    chk(rdat, 8'h3C);
    op(`PFC_OP_ERASE, 19'h00000, 8'h00);
    chk({7'h00, rto}, 8'h00);
    op(`PFC_OP_READ, 19'h00010, 8'h00);
    chk(rdat, 8'h3C);
    op(`PFC_OP_READ, 19'h04000, 8'h00);
    chk(rdat, 8'hFF);
  endtask
  // reset in mid read: strobes and the request port fall back to idle at once
  task automatic t_reset;
    @(posedge clock);
    req_valid <= 1; req_op <= `PFC_OP_READ; req_addr <= 19'h04000;
    @(posedge clock);
    req_valid <= 0;
    repeat (4) @(posedge clock);
    rst <= 1;
    @(posedge clock);
    chk({3'h0, req_ready, data_lines_oe, chip_sel_n, out_en_n, write_en_n}, 8'h17);
    chk({7'h00, resp_valid}, 8'h00);
    rst <= 0;
    op(`PFC_OP_READ, 19'h04000, 8'h00);
    chk(rdat, 8'hFF);
  endtask
  task automatic summarize;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog sized well above the expected run of some 40 us
  initial
  begin
    #2000000;
    mismatches++;
    summarize();
  end
  initial
  begin
    repeat (10) @(posedge clock);
    rst <= 0;
    t_read();
    t_program();
    t_ident();
    t_lock();
    t_reset();
    summarize();
  end
endmodule
bind pfc_host pfc_host_assertions pfc_host_assertions_inst (.clock(clock), .rst(rst), .req_ready(req_ready),
  .resp_valid(resp_valid), .addr_lines(addr_lines), .data_lines_out(data_lines_out),
  .data_lines_oe(data_lines_oe), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_en_n(write_en_n));
`default_nettype wire
